/* ccs_pkg.sv */
// Overview of operation
// R1 - three AC offset corrections: current RMS, active power, reactive power
// R2 - host scales offset corrections by the matching gain and range
// R3 - DC mode bypasses high-pass filters on current and voltage channels
// R4 - DC current offset added to each current ADC result first
// R5 - line frequency reported as 16-bit value from the voltage channel
// R6 - DC mode stops line frequency calculation and reports zero
// R7 - line frequency result valid only between 45 and 65 Hz
// R8 - frequency auto-calibration changes only the line frequency gain
// R9 - new gain is old times expected over measured; ACK if 25000..65535
// R10 - after ACK the host may save calibration to flash
// R11 - host runs frequency auto-calibration only on internal oscillator
// R12 - output = input times (1 + coefficient times (thermistor minus cal))
// R13 - coefficient is signed 16-bit over 2^26 (frequency) or 2^27
// R14 - coefficient registers for frequency, current, and shared power
// R15 - thermistor reading is in 10-bit ADC units
// R16 - host copies thermistor reading into ambient reference at cal start
// R17 - delimiter 0xA5A5 saved then reset restores factory calibration
// R18 - user store of 256 16-bit words in 32 pages
// R19 - page read 0x42 plus page; answer ACK, page data, checksum
// R20 - page write 0x50, page, 16 data bytes; store and ACK
// R21 - bulk erase 0x4F erases whole store and answers ACK
// R22 - page number above 31 gives NAK and leaves store unchanged
package ccs_pkg;
  // calibration bank, one word per entry, byte address = 4 * index
  localparam int CAL_N = 11;
  localparam int CI_OFS_IRMS = 0;
  localparam int CI_OFS_P = 1;
  localparam int CI_OFS_Q = 2;
  localparam int CI_DC_OFS = 3;
  localparam int CI_LF_REF = 4;
  localparam int CI_LF_GAIN = 5;
  localparam int CI_TC_LF = 6;
  localparam int CI_TC_I = 7;
  localparam int CI_TC_PWR = 8;
  localparam int CI_T_CAL = 9;
  localparam int CI_DELIM = 10;
  localparam logic [7:0] A_CTRL = 8'h2C;
  localparam logic [7:0] A_CMD = 8'h30;
  localparam logic [7:0] A_STATUS = 8'h34;
  localparam logic [7:0] A_LINE_FREQ = 8'h38;
  localparam logic [7:0] A_THERM = 8'h3C;
  localparam logic [7:0] A_BUF = 8'h40;
  localparam logic [7:0] A_CHKSUM = 8'h60;
  // field positions
  localparam int CTRL_DC = 0;
  localparam int ST_BUSY = 0;
  localparam int ST_ACK = 1;
  localparam int ST_NAK = 2;
  // command codes; the last three codes are this block's own
  localparam logic [7:0] CMD_PAGE_RD = 8'h42;
  localparam logic [7:0] CMD_PAGE_WR = 8'h50;
  localparam logic [7:0] CMD_ERASE = 8'h4F;
  localparam logic [7:0] CMD_AUTOCAL_LF = 8'h76;
  localparam logic [7:0] CMD_SAVE = 8'h53;
  localparam logic [7:0] CMD_RELOAD = 8'h52;
  // user store shape
  localparam int STORE_WORDS = 256;
  localparam int PAGE_WORDS = 8;
  localparam logic [7:0] LAST_PAGE = 8'h1F;
  localparam logic [15:0] ERASED = 16'hFFFF;
  // calibration constants
  localparam logic [15:0] DELIM_FACTORY = 16'hA5A5;
  localparam logic [31:0] GAIN_MIN = 32'h0000_61A8;
  localparam logic [31:0] GAIN_MAX = 32'h0000_FFFF;
  localparam int LF_GAIN_SHIFT = 15;
  localparam int TC_SHIFT_LF = 26;
  localparam int TC_SHIFT_IP = 27;
  localparam logic [15:0] LF_MIN_MHZ = 16'hAFC8;
  localparam logic [15:0] LF_MAX_MHZ = 16'hFDE8;
  localparam logic [15:0] DEF_LF_REF = 16'hC350;
  localparam logic [15:0] DEF_LF_GAIN = 16'h8000;
  localparam int DIV_STEPS = 32;

  // factory default of each calibration entry
  function automatic logic [15:0] calDefault(input int idx);
    calDefault = (idx == CI_LF_REF) ? DEF_LF_REF :
                 (idx == CI_LF_GAIN) ? DEF_LF_GAIN : 16'h0000;
  endfunction

  typedef enum {CS_IDLE, CS_EXEC, CS_DIV, CS_CHECK} ccs_state_t;
endpackage

/* ccs_temp_comp.sv */
`timescale 1ns/1ps
// y = x * (1 + coef * (therm - thermCal) / 2^SHIFT), purely combinational
module ccs_temp_comp
  import ccs_pkg::*;
#(
  parameter int W = 32,
  parameter int SHIFT = TC_SHIFT_IP
)
(
  input wire logic signed [W-1:0] x,
  input wire logic signed [15:0] coef,
  input wire logic [9:0] therm,
  input wire logic [9:0] thermCal,
  output logic signed [W-1:0] y
);
  logic signed [10:0] delta;
  logic signed [26:0] scale;
  logic signed [W+26:0] prod;

  // thermistor difference in 10-bit ADC units
  assign delta = $signed({1'b0, therm}) - $signed({1'b0, thermCal}); // R15
  assign scale = coef * delta; // R13
  assign prod = x * scale;
  // arithmetic shift keeps the sign of negative drift terms
  assign y = x + (W)'(prod >>> SHIFT); // R12
endmodule

/* ccs_top.sv */
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
module ccs_top
  import ccs_pkg::*;
#(
  parameter int ADC_W = 24,
  parameter int W = 32
)
(
  input wire logic clock,
  input wire logic srst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic signed [ADC_W-1:0] curAdc,
  input wire logic curAdcValid,
  output logic signed [ADC_W-1:0] curCorr,
  output logic curCorrValid,
  output logic hpfBypass,
  input wire logic [15:0] lfRaw,
  input wire logic signed [W-1:0] irmsRaw,
  input wire logic signed [W-1:0] pRaw,
  input wire logic signed [W-1:0] qRaw,
  input wire logic [9:0] therm,
  output logic [15:0] lineFreq,
  output logic lineFreqValid,
  output logic signed [W-1:0] irmsOut,
  output logic signed [W-1:0] pOut,
  output logic signed [W-1:0] qOut
);
  logic [15:0] cal_reg [CAL_N];
  logic [15:0] flash_reg [CAL_N];
  logic flashValid_reg;
  logic [15:0] store_reg [STORE_WORDS];
  logic [15:0] buf_reg [PAGE_WORDS];
  logic [7:0] chk_reg;
  logic dcMode_reg;
  ccs_state_t state_reg;
  logic [7:0] cmd_reg;
  logic [7:0] page_reg;
  logic ack_reg;
  logic nak_reg;
  logic [31:0] quot_reg;
  logic [16:0] rem_reg;
  logic [5:0] step_reg;
  logic [15:0] divisor_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic signed [ADC_W-1:0] curCorr_reg;
  logic curCorrValid_reg;
  logic hpfBypass_reg;
  logic [15:0] lineFreq_reg;
  logic lineFreqValid_reg;
  logic signed [W-1:0] irms_reg;
  logic signed [W-1:0] p_reg;
  logic signed [W-1:0] q_reg;

  logic acc;
  logic wrAcc;
  logic cmdStart;
  logic pageOk;
  logic [16:0] remShift;
  logic [31:0] lfGained;
  logic signed [W-1:0] compIn [4];
  logic signed [W-1:0] compOut [4];
  logic signed [15:0] compCoef [4];
  logic [15:0] lfNext;
  logic [7:0] chkNext;

  // address decode helpers, used by both read and write paths
  function automatic logic isCal(input logic [7:0] a);
    isCal = (a[1:0] == 2'b00) && (a < 8'(CAL_N * 4));
  endfunction
  function automatic logic isBuf(input logic [7:0] a);
    isBuf = (a[1:0] == 2'b00) && (a >= A_BUF) && (a < 8'(A_BUF + PAGE_WORDS * 4));
  endfunction

  ////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, answer registered
  assign acc = psel && penable && pready_reg;
  assign wrAcc = acc && pwrite && !pslverr_reg;
  assign cmdStart = wrAcc && (paddr == A_CMD);

  // ready rises one edge into the access phase, drops after it
  always_ff @(posedge clock)
  begin
    if (srst)
      pready_reg <= 1'b0;
    else
      pready_reg <= psel && penable && !pready_reg;
  end

  // error on unmapped address, read-only write, command register read, or command while busy
  always_ff @(posedge clock)
  begin
    if (srst)
      pslverr_reg <= 1'b0;
    else if (psel && penable && !pready_reg)
    begin
      if (isCal(paddr) || isBuf(paddr) || paddr == A_CTRL)
        pslverr_reg <= 1'b0;
      else if (paddr == A_CMD)
        pslverr_reg <= !pwrite || (state_reg != CS_IDLE);
      else if (paddr == A_STATUS || paddr == A_LINE_FREQ || paddr == A_THERM
               || paddr == A_CHKSUM)
        pslverr_reg <= pwrite;
      else
        pslverr_reg <= 1'b1;
    end
    else
      pslverr_reg <= 1'b0;
  end

  // read data, low bits carry the value, upper bits read zero
  always_ff @(posedge clock)
  begin
    if (srst)
      prdata_reg <= 32'h0000_0000;
    else if (psel && penable && !pready_reg && !pwrite)
    begin
      prdata_reg <= 32'h0000_0000;
      if (isCal(paddr))
        prdata_reg[15:0] <= cal_reg[paddr[5:2]];
      else if (isBuf(paddr))
        prdata_reg[15:0] <= buf_reg[paddr[4:2]];
      else if (paddr == A_CTRL)
        prdata_reg[CTRL_DC] <= dcMode_reg;
      else if (paddr == A_STATUS)
        prdata_reg[2:0] <= {nak_reg, ack_reg, state_reg != CS_IDLE};
      else if (paddr == A_LINE_FREQ)
        prdata_reg[15:0] <= lineFreq_reg;
      else if (paddr == A_THERM)
        prdata_reg[9:0] <= therm; // R15
      else if (paddr == A_CHKSUM)
        prdata_reg[7:0] <= chk_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // mode control
  always_ff @(posedge clock)
  begin
    if (srst)
      dcMode_reg <= 1'b0;
    else if (wrAcc && paddr == A_CTRL)
      dcMode_reg <= pwdata[CTRL_DC];
  end

  // calibration bank: software writes, auto-calibration, reload
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      for (int i = 0; i < CAL_N; i++)
        cal_reg[i] <= calDefault(i);
    end
    else if (state_reg == CS_CHECK && quot_reg >= GAIN_MIN && quot_reg <= GAIN_MAX)
      cal_reg[CI_LF_GAIN] <= quot_reg[15:0]; // R8 R9
    else if (state_reg == CS_EXEC && cmd_reg == CMD_RELOAD)
    begin
      // a saved delimiter of A5A5 leaves the bank invalid: factory values
      for (int i = 0; i < CAL_N; i++)
        cal_reg[i] <= flashValid_reg ? flash_reg[i] : calDefault(i); // R17
    end
    else if (wrAcc && isCal(paddr))
      cal_reg[paddr[5:2]] <= pwdata[15:0]; // R1 R14
  end

  // saved image of the calibration bank, cleared to factory values by reset
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      flashValid_reg <= 1'b0;
      for (int i = 0; i < CAL_N; i++)
        flash_reg[i] <= calDefault(i);
    end
    else if (state_reg == CS_EXEC && cmd_reg == CMD_SAVE)
    begin
      flashValid_reg <= cal_reg[CI_DELIM] != DELIM_FACTORY; // R17
      for (int i = 0; i < CAL_N; i++)
        flash_reg[i] <= cal_reg[i];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // command sequencer
  assign pageOk = page_reg <= LAST_PAGE; // R22
  assign remShift = {rem_reg[15:0], quot_reg[31]};

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state_reg <= CS_IDLE;
      cmd_reg <= 8'h00;
      page_reg <= 8'h00;
    end
    else
    begin
      unique case (state_reg)
        CS_IDLE:
          if (cmdStart)
          begin
            cmd_reg <= pwdata[7:0];
            page_reg <= pwdata[15:8];
            state_reg <= CS_EXEC;
          end
        CS_EXEC:
          // a zero measurement cannot be divided by, so it fails at once
          if (cmd_reg == CMD_AUTOCAL_LF && lineFreq_reg != 16'h0000)
            state_reg <= CS_DIV;
          else
            state_reg <= CS_IDLE;
        CS_DIV:
          if (step_reg == 6'(DIV_STEPS - 1))
            state_reg <= CS_CHECK;
        CS_CHECK:
          state_reg <= CS_IDLE;
      endcase
    end
  end

  // restoring divider: old gain times expected over measured
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      quot_reg <= 32'h0000_0000;
      rem_reg <= 17'h0_0000;
      step_reg <= 6'h00;
      divisor_reg <= 16'h0000;
    end
    else if (state_reg == CS_EXEC)
    begin
      quot_reg <= cal_reg[CI_LF_GAIN] * cal_reg[CI_LF_REF]; // R9
      rem_reg <= 17'h0_0000;
      step_reg <= 6'h00;
      divisor_reg <= lineFreq_reg;
    end
    else if (state_reg == CS_DIV)
    begin
      step_reg <= step_reg + 6'h01;
      if (remShift >= {1'b0, divisor_reg})
      begin
        rem_reg <= remShift - {1'b0, divisor_reg};
        quot_reg <= {quot_reg[30:0], 1'b1};
      end
      else
      begin
        rem_reg <= remShift;
        quot_reg <= {quot_reg[30:0], 1'b0};
      end
    end
  end

  // answer flags: cleared when a command starts, set when it ends
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      ack_reg <= 1'b0;
      nak_reg <= 1'b0;
    end
    else if (cmdStart && state_reg == CS_IDLE)
    begin
      ack_reg <= 1'b0;
      nak_reg <= 1'b0;
    end
    else if (state_reg == CS_CHECK)
    begin
      ack_reg <= quot_reg >= GAIN_MIN && quot_reg <= GAIN_MAX; // R9
      nak_reg <= !(quot_reg >= GAIN_MIN && quot_reg <= GAIN_MAX); // R9
    end
    else if (state_reg == CS_EXEC && !(cmd_reg == CMD_AUTOCAL_LF && lineFreq_reg != 16'h0000))
    begin
      if (cmd_reg == CMD_PAGE_RD || cmd_reg == CMD_PAGE_WR)
      begin
        ack_reg <= pageOk; // R19 R20
        nak_reg <= !pageOk; // R22
      end
      else if (cmd_reg == CMD_ERASE || cmd_reg == CMD_SAVE || cmd_reg == CMD_RELOAD)
        ack_reg <= 1'b1; // R21
      else
        nak_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // user store, erased state is all ones
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      for (int i = 0; i < STORE_WORDS; i++)
        store_reg[i] <= ERASED;
    end
    else if (state_reg == CS_EXEC && cmd_reg == CMD_ERASE)
    begin
      for (int i = 0; i < STORE_WORDS; i++)
        store_reg[i] <= ERASED; // R21
    end
    else if (state_reg == CS_EXEC && cmd_reg == CMD_PAGE_WR && pageOk) // R22
    begin
      for (int i = 0; i < PAGE_WORDS; i++)
        store_reg[{page_reg[4:0], 3'(i)}] <= buf_reg[i]; // R18 R20
    end
  end

  // checksum of the sixteen page bytes, modulo 256
  always_comb
  begin
    chkNext = 8'h00;
    for (int i = 0; i < PAGE_WORDS; i++)
      chkNext = chkNext + store_reg[{page_reg[4:0], 3'(i)}][15:8]
                + store_reg[{page_reg[4:0], 3'(i)}][7:0];
  end

  // page buffer: software fills it for writes, page read loads it
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      chk_reg <= 8'h00;
      for (int i = 0; i < PAGE_WORDS; i++)
        buf_reg[i] <= ERASED;
    end
    else if (state_reg == CS_EXEC && cmd_reg == CMD_PAGE_RD && pageOk)
    begin
      chk_reg <= chkNext; // R19
      for (int i = 0; i < PAGE_WORDS; i++)
        buf_reg[i] <= store_reg[{page_reg[4:0], 3'(i)}]; // R19
    end
    else if (wrAcc && isBuf(paddr))
      buf_reg[paddr[4:2]] <= pwdata[15:0];
  end

  ////////////////////////////////////////////////////////////////////
  // current sample path: offset added before anything else sees it
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      curCorr_reg <= '0;
      curCorrValid_reg <= 1'b0;
      hpfBypass_reg <= 1'b0;
    end
    else
    begin
      curCorr_reg <= curAdc + (ADC_W)'($signed(cal_reg[CI_DC_OFS])); // R4
      curCorrValid_reg <= curAdcValid;
      hpfBypass_reg <= dcMode_reg; // R3
    end
  end

  // gain applied to the raw frequency count, then compensated
  assign lfGained = (lfRaw * cal_reg[CI_LF_GAIN]) >> LF_GAIN_SHIFT;
  assign compIn[0] = (W)'($signed({1'b0, lfGained}));
  assign compIn[1] = irmsRaw + (W)'($signed(cal_reg[CI_OFS_IRMS])); // R1
  assign compIn[2] = pRaw + (W)'($signed(cal_reg[CI_OFS_P])); // R1
  assign compIn[3] = qRaw + (W)'($signed(cal_reg[CI_OFS_Q])); // R1
  assign compCoef[0] = cal_reg[CI_TC_LF]; // R14
  assign compCoef[1] = cal_reg[CI_TC_I]; // R14
  assign compCoef[2] = cal_reg[CI_TC_PWR]; // R14
  assign compCoef[3] = cal_reg[CI_TC_PWR]; // R14

  // one compensator per output; frequency uses the coarser scale
  for (genvar g = 0; g < 4; g++)
  begin : gComp
    ccs_temp_comp #(
      .W(W),
      .SHIFT((g == 0) ? TC_SHIFT_LF : TC_SHIFT_IP) // R13
    ) uComp (
      .x(compIn[g]),
      .coef(compCoef[g]),
      .therm(therm),
      .thermCal(cal_reg[CI_T_CAL][9:0]),
      .y(compOut[g])
    );
  end

  // dc mode forces zero rather than a stale value
  assign lfNext = dcMode_reg ? 16'h0000 : compOut[0][15:0]; // R5 R6

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      lineFreq_reg <= 16'h0000;
      lineFreqValid_reg <= 1'b0;
      irms_reg <= '0;
      p_reg <= '0;
      q_reg <= '0;
    end
    else
    begin
      lineFreq_reg <= lfNext; // R6 R12
      lineFreqValid_reg <= !dcMode_reg && lfNext >= LF_MIN_MHZ && lfNext <= LF_MAX_MHZ; // R7
      irms_reg <= compOut[1]; // R12
      p_reg <= compOut[2]; // R12
      q_reg <= compOut[3]; // R12
    end
  end

  ////////////////////////////////////////////////////////////////////
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign curCorr = curCorr_reg;
  assign curCorrValid = curCorrValid_reg;
  assign hpfBypass = hpfBypass_reg;
  assign lineFreq = lineFreq_reg;
  assign lineFreqValid = lineFreqValid_reg;
  assign irmsOut = irms_reg;
  assign pOut = p_reg;
  assign qOut = q_reg;
endmodule

/* ccs_chk.sv */
`timescale 1ns/1ps
module ccs_chk
  import ccs_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic curAdcValid,
  input wire logic curCorrValid,
  input wire logic hpfBypass,
  input wire logic [15:0] lineFreq,
  input wire logic lineFreqValid
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////
  // bus phases as the slave sees them
  sequence setupPh;
    psel && !penable;
  endsequence
  sequence accessPh;
    psel && penable;
  endsequence
  // one wait state always, so the answer lands on the second access cycle
  ready_timing_a: assert property (setupPh ##1 accessPh |-> ##1 pready)
    else $error("answer not on second access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  ready_access_a: assert property (pready |-> accessPh)
    else $error("ready outside access phase");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  corr_valid_a: assert property (curAdcValid |=> curCorrValid)
    else $error("corrected sample missing");
  corr_quiet_a: assert property (!curAdcValid |=> !curCorrValid)
    else $error("corrected sample without input");
  dc_freq_zero_a: assert property (hpfBypass |-> lineFreq == 16'h0000 && !lineFreqValid)
    else $error("line frequency not zero in dc mode");
  freq_range_a: assert property (lineFreqValid |-> lineFreq >= LF_MIN_MHZ && lineFreq <= LF_MAX_MHZ)
    else $error("valid flag outside frequency range");
endmodule

bind ccs_top ccs_chk u_ccs_chk (.clock(clock), .srst(srst), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .curAdcValid(curAdcValid), .curCorrValid(curCorrValid),
  .hpfBypass(hpfBypass), .lineFreq(lineFreq), .lineFreqValid(lineFreqValid));

/* ccs_host.sv */
`timescale 1ns/1ps
// host side: bus master plus command helpers, all changes just after an edge
module ccs_host
  import ccs_pkg::*;
(
  input wire logic clock,
  output logic [7:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // idle bus from time zero
  initial
  begin
    paddr = 8'hFF;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'hFFFF_FFFF;
  end
  ////////////////////////////////////////////////////////////////
  // request held until pready is seen high at an edge, then released
  task automatic xfer(input logic [7:0] a, input logic w, input logic [15:0] d,
    output logic [31:0] rdat, output logic err);
    @(posedge clock);
    paddr <= a;
    pwrite <= w;
    pwdata <= {16'h0000, d};
    psel <= 1'b1;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
      @(posedge clock);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released address and data lines show junk, not the last value; pwrite keeps its last value
    paddr <= ~a;
    pwdata <= ~{16'h0000, d};
  endtask
  // command then poll until busy drops; never overlaps commands
  task automatic cmd(input logic [7:0] code, input logic [7:0] pg, output logic [31:0] st);
    logic e;
    xfer(A_CMD, 1'b1, {pg, code}, st, e);
    st = 32'h0000_0001;
    while (st[ST_BUSY] !== 1'b0)
      xfer(A_STATUS, 1'b0, 16'h0000, st, e);
  endtask
  // copy present thermistor reading into the ambient reference
  task automatic calStart();
    logic [31:0] t;
    logic [31:0] x;
    logic e;
    xfer(A_THERM, 1'b0, 16'h0000, t, e);
    xfer(8'(4 * CI_T_CAL), 1'b1, t[15:0], x, e);
  endtask
endmodule

/* ccs_bench.sv */
`timescale 1ns/1ps
module ccs_bench
  import ccs_pkg::*;
;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [7:0] paddr;
  logic psel, penable, pwrite, pready, pslverr, e;
  logic [31:0] pwdata, prdata;
  logic curAdcValid = 1'b0;
  logic curCorrValid, hpfBypass, lineFreqValid;
  logic signed [23:0] curAdc = 24'h000000;
  logic signed [23:0] curCorr;
  logic [15:0] lfRaw = 16'hC350;
  logic [15:0] lineFreq;
  logic [9:0] therm = 10'h000;
  logic signed [31:0] irmsRaw = 32'h0000_1000;
  logic signed [31:0] pRaw = 32'h0000_1000;
  logic signed [31:0] qRaw = 32'h0000_1000;
  logic signed [31:0] irmsOut, pOut, qOut;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;

  ccs_top u_ccs_top (.clock(clock), .srst(srst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .curAdc(curAdc), .curAdcValid(curAdcValid), .curCorr(curCorr),
    .curCorrValid(curCorrValid), .hpfBypass(hpfBypass), .lfRaw(lfRaw), .irmsRaw(irmsRaw),
    .pRaw(pRaw), .qRaw(qRaw), .therm(therm), .lineFreq(lineFreq),
    .lineFreqValid(lineFreqValid), .irmsOut(irmsOut), .pOut(pOut), .qOut(qOut));
  ccs_host u_ccs_host (.clock(clock), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // 25 MHz
  always #20 clock = ~clock;
  ////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    u_ccs_host.xfer(a, 1'b0, 16'h0000, d, e);
    chk(d, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] x;
    u_ccs_host.xfer(a, 1'b1, d, x, e);
    chk({31'h0, e}, 32'h0);
  endtask
  task automatic cm(input logic [7:0] c, input logic [7:0] p, input logic [31:0] exp);
    logic [31:0] s;
    u_ccs_host.cmd(c, p, s);
    chk(s, exp);
  endtask
  function automatic logic [7:0] ca(input int i);
    ca = 8'(4 * i);
  endfunction
  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(ca(CI_LF_REF), 32'h0000_C350);
    rd(ca(CI_LF_GAIN), 32'h0000_8000);
    rd(A_BUF, 32'h0000_FFFF);
    rd(8'h64, 32'h0000_0000);
    chk({31'h0, e}, 32'h1);
    $display("test reset done");
  endtask
  task automatic t_offset();
    wr(ca(CI_OFS_IRMS), 16'h0010);
    wr(ca(CI_OFS_P), 16'h0020);
    wr(ca(CI_OFS_Q), 16'h0030);
    wr(ca(CI_DC_OFS), 16'hFFFE);
    @(posedge clock);
    curAdc <= 24'h000064;
    curAdcValid <= 1'b1;
    @(posedge clock);
    curAdcValid <= 1'b0;
    #1;
    chk({31'h0, curCorrValid}, 32'h1);
    chk({8'h00, curCorr}, 32'h0000_0062);
    chk(irmsOut, 32'h0000_1010);
    chk(pOut, 32'h0000_1020);
    chk(qOut, 32'h0000_1030);
    wr(A_CTRL, 16'h0001);
    repeat (2) @(posedge clock);
    #1;
    chk({31'h0, hpfBypass}, 32'h1);
    rd(A_LINE_FREQ, 32'h0000_0000);
    cm(CMD_AUTOCAL_LF, 8'h00, 32'h0000_0004);
    wr(A_CTRL, 16'h0000);
    $display("test offset done");
  endtask
  // band edges: one step below the low edge, the high edge itself and one step above it
  task automatic t_freq();
    logic [15:0] f [4] = '{16'hC350, 16'hAFC7, 16'hFDE8, 16'hFDE9};
    logic v [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clock);
      lfRaw <= f[i];
      repeat (2) @(posedge clock);
      #1;
      chk({16'h0, lineFreq}, {16'h0, f[i]});
      chk({31'h0, lineFreqValid}, {31'h0, v[i]});
    end
    $display("test freq done");
  endtask
  task automatic t_autocal();
    @(posedge clock);
    lfRaw <= 16'h9C40;
    cm(CMD_AUTOCAL_LF, 8'h00, 32'h0000_0002);
    rd(ca(CI_LF_GAIN), 32'h0000_A000);
    rd(ca(CI_LF_REF), 32'h0000_C350);
    @(posedge clock);
    lfRaw <= 16'h2710;
    cm(CMD_AUTOCAL_LF, 8'h00, 32'h0000_0004);
    rd(ca(CI_LF_GAIN), 32'h0000_A000);
    wr(ca(CI_LF_GAIN), 16'h8000);
    $display("test autocal done");
  endtask
  // thermistor 256 counts above reference gives a 1/32 step on current and frequency, 1/64 on power
  task automatic t_comp();
    @(posedge clock);
    therm <= 10'h200;
    lfRaw <= 16'hC350;
    u_ccs_host.calStart();
    @(posedge clock);
    therm <= 10'h300;
    wr(ca(CI_TC_I), 16'h4000);
    wr(ca(CI_TC_PWR), 16'h2000);
    wr(ca(CI_TC_LF), 16'h2000);
    repeat (2) @(posedge clock);
    #1;
    chk(irmsOut, 32'h0000_1090);
    chk(pOut, 32'h0000_1060);
    chk(qOut, 32'h0000_1070);
    chk({16'h0, lineFreq}, 32'h0000_C96A);
    $display("test comp done");
  endtask
  task automatic t_store();
    for (int i = 0; i < 8; i++)
      wr(A_BUF + 8'(4 * i), 16'h1100 + 16'(i));
    cm(CMD_PAGE_WR, LAST_PAGE, 32'h0000_0002);
    for (int i = 0; i < 8; i++)
      wr(A_BUF + 8'(4 * i), 16'h0000);
    cm(CMD_PAGE_RD, LAST_PAGE, 32'h0000_0002);
    for (int i = 0; i < 8; i++)
      rd(A_BUF + 8'(4 * i), 32'h0000_1100 + 32'(i));
    rd(A_CHKSUM, 32'h0000_00A4);
    cm(CMD_PAGE_WR, 8'h20, 32'h0000_0004);
    cm(CMD_PAGE_RD, 8'h20, 32'h0000_0004);
    rd(A_BUF, 32'h0000_1100);
    cm(CMD_PAGE_RD, 8'h00, 32'h0000_0002);
    rd(A_BUF, 32'h0000_FFFF);
    cm(8'h11, 8'h00, 32'h0000_0004);
    cm(CMD_ERASE, 8'h00, 32'h0000_0002);
    cm(CMD_PAGE_RD, LAST_PAGE, 32'h0000_0002);
    rd(A_BUF + 8'h1C, 32'h0000_FFFF);
    rd(A_CHKSUM, 32'h0000_00F0);
    $display("test store done");
  endtask
  task automatic t_factory();
    wr(ca(CI_LF_GAIN), 16'h9000);
    cm(CMD_SAVE, 8'h00, 32'h0000_0002);
    wr(ca(CI_LF_GAIN), 16'h7000);
    cm(CMD_RELOAD, 8'h00, 32'h0000_0002);
    rd(ca(CI_LF_GAIN), 32'h0000_9000);
    wr(ca(CI_DELIM), 16'hA5A5);
    cm(CMD_SAVE, 8'h00, 32'h0000_0002);
    cm(CMD_RELOAD, 8'h00, 32'h0000_0002);
    rd(ca(CI_LF_GAIN), 32'h0000_8000);
    rd(ca(CI_OFS_IRMS), 32'h0000_0000);
    $display("test factory done");
  endtask
  ////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_offset();
    t_freq();
    t_autocal();
    t_comp();
    t_store();
    t_factory();
    end_sim();
  end
endmodule
